/* File: common/touch_ctrl_pkg.sv */
// Register map, field layout and fixed codes of the touch controller host register bank.
package touch_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MEM_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COMP_MODE  = 8'h09;
  localparam logic [7:0] ADDR_GPO_CTRL   = 8'h0a;
  localparam logic [7:0] ADDR_PIN_SELECT = 8'h0b;
  localparam logic [7:0] ADDR_INTENSITY  = 8'h0c;
  localparam logic [7:0] ADDR_GW_CONFIG  = 8'h0d;
  localparam logic [7:0] ADDR_BURST_BASE = 8'h0e;
  localparam logic [7:0] ADDR_KEY_UPPER  = 8'hac;
  localparam logic [7:0] ADDR_KEY_LOWER  = 8'had;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'hb1;

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int         MODE_COMP_BIT  = 2;
  localparam int         GW_EN_LSB      = 4;
  localparam int         GW_DIR_BIT     = 3;
  localparam logic [1:0] GW_EN_ON       = 2'h1;
  localparam logic [1:0] MODE_ACTIVE    = 2'h0;
  localparam logic [1:0] MODE_SLEEP     = 2'h2;
  localparam logic [1:0] MODE_RESERVED  = 2'h3;
  localparam logic [2:0] BURN_COUNT_MAX = 3'h4;
  localparam logic [2:0] BURN_COUNT_LIM = 3'h3;

  // ----------------------------------------------------------------
  // Burst window and parameter memory
  // ----------------------------------------------------------------
  localparam int         BURST_LEN  = 8;
  localparam int         MEM_BYTES  = 128;
  localparam logic [7:0] BURST_FULL = 8'hff;

  // ----------------------------------------------------------------
  // Key and sequence bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_UPPER_VAL = 8'h62;
  localparam logic [7:0] KEY_LOWER_VAL = 8'h9d;
  localparam logic [7:0] BURN_GO_1     = 8'ha5;
  localparam logic [7:0] BURN_GO_2     = 8'h5a;
  localparam logic [7:0] SOFT_RST_1    = 8'hde;
  localparam logic [7:0] SOFT_RST_2    = 8'h00;

endpackage : touch_ctrl_pkg

/* File: src/i2c_reg_slave.sv */
// I2C slave byte engine with an auto-incrementing register pointer.
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2b
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe_o,
  output logic [7:0]      ptr_o,
  output logic            wr_stb_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  input  wire logic [7:0] rd_data_i,
  output logic            rd_stb_o,
  output logic [7:0]      rd_addr_o,
  output logic            stop_o
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WBYTE, S_ACK, S_RBYTE, S_MACK, S_MSAMP} state_t;

  state_t     st_q, st_d;
  logic [7:0] shift_q, shift_d, ptr_q, ptr_d, wa_q, wa_d, wd_q, wd_d, ra_q, ra_d;
  logic [2:0] bit_q, bit_d;
  logic       scl_q, sda_q, oe_q, oe_d, rw_q, rw_d, first_q, first_d, flag_q, flag_d;
  logic       wst_q, wst_d, rst_q, rst_d, stop_q, stop_d;
  logic       rise, fall, start, stop;
  logic [7:0] nb;

  assign rise  = scl_i & ~scl_q;
  assign fall  = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop  = scl_i & scl_q & ~sda_q & sda_i;
  assign nb    = {shift_q[6:0], sda_i};

  always_comb begin
    st_d = st_q; shift_d = shift_q; ptr_d = ptr_q; wa_d = wa_q; wd_d = wd_q; ra_d = ra_q;
    bit_d = bit_q; oe_d = oe_q; rw_d = rw_q; first_d = first_q; flag_d = flag_q;
    wst_d = 1'b0; rst_d = 1'b0; stop_d = 1'b0;
    if (start) begin
      st_d = S_ADDR; bit_d = 3'h0; first_d = 1'b1; oe_d = 1'b0;
    end else if (stop) begin
      st_d = S_IDLE; oe_d = 1'b0; stop_d = 1'b1;
    end else begin
      unique case (st_q)
        S_IDLE: ;
        S_ADDR, S_WBYTE: if (rise) begin
          shift_d = nb;
          bit_d   = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            flag_d = 1'b0;
            st_d   = S_ACK;
            if (st_q == S_ADDR) begin
              rw_d = nb[0];
              if (nb[7:1] != DEV_ADDR) st_d = S_IDLE;
            end else if (first_q) begin
              ptr_d = nb; first_d = 1'b0;
            end else begin
              wst_d = 1'b1; wa_d = ptr_q; wd_d = nb; ptr_d = ptr_q + 8'h01;
            end
          end
        end
        S_ACK: if (fall) begin
          if (!flag_q) begin
            oe_d = 1'b1; flag_d = 1'b1;
          end else if (rw_q) begin
            shift_d = rd_data_i; oe_d = ~rd_data_i[7]; rst_d = 1'b1; ra_d = ptr_q;
            ptr_d = ptr_q + 8'h01; bit_d = 3'h0; st_d = S_RBYTE;
          end else begin
            oe_d = 1'b0; st_d = S_WBYTE;
          end
        end
        S_RBYTE: begin
          if (fall) begin
            shift_d = {shift_q[6:0], 1'b0}; oe_d = ~shift_q[6];
          end
          if (rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) st_d = S_MACK;
          end
        end
        S_MACK: if (fall) begin
          oe_d = 1'b0; flag_d = 1'b0; st_d = S_MSAMP;
        end
        S_MSAMP: begin
          // A master NACK ends the read; the pointer already sits past the last byte.
          if (rise) begin
            if (sda_i) st_d = S_IDLE;
            else flag_d = 1'b1;
          end
          if (fall && flag_q) begin
            shift_d = rd_data_i; oe_d = ~rd_data_i[7]; rst_d = 1'b1; ra_d = ptr_q;
            ptr_d = ptr_q + 8'h01; bit_d = 3'h0; st_d = S_RBYTE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= S_IDLE; shift_q <= 8'h00; ptr_q <= 8'h00; wa_q <= 8'h00; wd_q <= 8'h00; ra_q <= 8'h00;
      bit_q <= 3'h0; scl_q <= 1'b1; sda_q <= 1'b1; oe_q <= 1'b0; rw_q <= 1'b0; first_q <= 1'b0;
      flag_q <= 1'b0; wst_q <= 1'b0; rst_q <= 1'b0; stop_q <= 1'b0;
    end else begin
      st_q <= st_d; shift_q <= shift_d; ptr_q <= ptr_d; wa_q <= wa_d; wd_q <= wd_d; ra_q <= ra_d;
      bit_q <= bit_d; scl_q <= scl_i; sda_q <= sda_i; oe_q <= oe_d; rw_q <= rw_d; first_q <= first_d;
      flag_q <= flag_d; wst_q <= wst_d; rst_q <= rst_d; stop_q <= stop_d;
    end
  end

  assign sda_oe_o  = oe_q;
  assign ptr_o     = ptr_q;
  assign wr_stb_o  = wst_q;
  assign wr_addr_o = wa_q;
  assign wr_data_o = wd_q;
  assign rd_stb_o  = rst_q;
  assign rd_addr_o = ra_q;
  assign stop_o    = stop_q;
endmodule : i2c_reg_slave
`default_nettype wire

/* File: src/touch_ctrl_host_register_bank.sv */
// Host register bank of the touch controller behind an I2C slave port.
//
// Contract
// - Status bit 3 shows burned parameters valid.
// - Burn count 0..4; four forces factory set.
// - Mode bit 2 starts and shows compensation.
// - Mode bits 1:0 select active, doze, sleep.
// - Mode upper bits written zero, read arbitrary.
// - Output bits switch pins on or off.
// - Output bits reset from power-up state; masked.
// - Pin selector chooses addressed pulse-width pin.
// - Intensity register sets and reads selected pin.
// - Pin default intensity is on or off level.
// - Writes 0xDE then 0x00 reset chip.
// - Gateway bits 5:4 equal 01 enable access.
// - Gateway bit 3 picks read or write.
// - Burst base aligned to eight, up to 0x78.
// - Memory exchange always in eight-byte bursts; only writes are staged as bursts, reads return any window byte on its own.
// - Upper burn key must hold 0x62.
// - Lower burn key must hold 0x9D.
// - Burn starts on 0xA5, 0x5A, then STOP.
// - Burst bytes use I2C addresses 0 to 7.
// - Finished burn sets flag and interrupt line.
`timescale 1ns/1ps
`default_nettype none
module touch_ctrl_host_register_bank #(
  parameter logic [6:0] DEV_ADDR    = 7'h2b, // Arbitrary slave address.
  parameter int         COMP_CYCLES = 64,
  parameter int         BURN_CYCLES = 256
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic [7:0]  output_powerup_state_i,
  input  wire logic [7:0]  gpo_pin_mask_i,
  input  wire logic [7:0]  on_level_i,
  input  wire logic [7:0]  off_level_i,
  input  wire logic        autolight_en_i,
  input  wire logic        burn_flag_clear_i,
  output logic [1:0]       op_mode_o,
  output logic             comp_running_o,
  output logic [7:0]       general_output_pin_o,
  output logic [63:0]      pwm_intensity_o,
  output logic             param_access_on_o,
  output logic             burn_busy_o,
  output logic             burn_flag_o,
  output logic             interrupt_line_n_o,
  output logic             soft_reset_o
);
  if (COMP_CYCLES < 1 || COMP_CYCLES > 65535 || BURN_CYCLES < 1 || BURN_CYCLES > 65535) begin : g_chk_cycles
    $error("cycle count out of range");
  end

  // ----------------------------------------------------------------
  // Reset release and I2C engine
  // ----------------------------------------------------------------
  logic [1:0] rsync_q;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rsync_q <= 2'h0;
    else rsync_q <= {rsync_q[0], 1'b1};
  end
  assign rst_n = rsync_q[1];
  logic [7:0] ptr, wa, wd, rd_data, ra;
  logic       wr, rd, stop;
  i2c_reg_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_oe_o  (sda_oe_o),
    .ptr_o     (ptr),
    .wr_stb_o  (wr),
    .wr_addr_o (wa),
    .wr_data_o (wd),
    .rd_data_i (rd_data),
    .rd_stb_o  (rd),
    .rd_addr_o (ra),
    .stop_o    (stop)
  );
  assign sda_o = 1'b0;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  gpo_q, gpo_d, base_q, base_d, khi_q, khi_d, klo_q, klo_d, mask_q, mask_d;
  logic [7:0]  inten_q [8], inten_d [8];
  logic [7:0]  stage_q [8], stage_d [8];
  logic [7:0]  mem_q [touch_ctrl_pkg::MEM_BYTES];
  logic [1:0]  mode_q, mode_d, gwen_q, gwen_d, seq_q, seq_d;
  logic [2:0]  sel_q, sel_d, cnt_q, cnt_d;
  logic [15:0] ctmr_q, ctmr_d, btmr_q, btmr_d;
  logic        init_q, init_d, comp_q, comp_d, dir_q, dir_d, busy_q, busy_d, valid_q, valid_d;
  logic        flag_q, flag_d, irqn_q, irqn_d, arm_q, arm_d, srp_q, srp_d, acc_q, acc_d;
  logic        gw_on;
  assign gw_on = (gwen_q == touch_ctrl_pkg::GW_EN_ON);
  // Addresses 0..7 reach the burst window only while access mode is on.
  function automatic logic in_window(input logic [7:0] a, input logic on);
    in_window = on && (a < 8'(touch_ctrl_pkg::BURST_LEN));
  endfunction : in_window

  always_comb begin
    gpo_d = gpo_q; base_d = base_q; khi_d = khi_q; klo_d = klo_q; mask_d = mask_q;
    inten_d = inten_q; stage_d = stage_q; mode_d = mode_q; gwen_d = gwen_q; seq_d = seq_q;
    sel_d = sel_q; cnt_d = cnt_q; ctmr_d = ctmr_q; btmr_d = btmr_q; init_d = init_q;
    comp_d = comp_q; dir_d = dir_q; busy_d = busy_q; valid_d = valid_q; flag_d = flag_q;
    arm_d = arm_q; srp_d = 1'b0;
    // The power-up state is a port, so it is loaded by the first clocked cycle after release.
    if (!init_q) begin
      init_d = 1'b1;
      gpo_d  = output_powerup_state_i;
      for (int i = 0; i < 8; i++) begin
        inten_d[i] = output_powerup_state_i[i] ? on_level_i : off_level_i;
      end
    end
    if (comp_q) begin
      if (ctmr_q == 16'h0000) comp_d = 1'b0;
      else ctmr_d = ctmr_q - 16'h0001;
    end
    if (burn_flag_clear_i) flag_d = 1'b0;
    if (busy_q) begin
      if (btmr_q == 16'h0000) begin
        busy_d = 1'b0;
        flag_d = 1'b1;
        if (cnt_q != touch_ctrl_pkg::BURN_COUNT_MAX) cnt_d = cnt_q + 3'h1;
        valid_d = (cnt_q < touch_ctrl_pkg::BURN_COUNT_LIM);
      end else begin
        btmr_d = btmr_q - 16'h0001;
      end
    end
    // A complete burst is committed and the stage empties; leaving access mode drops a partial one.
    if (mask_q == touch_ctrl_pkg::BURST_FULL || !gw_on) mask_d = 8'h00;
    if (wr) begin
      if (in_window(wa, gw_on)) begin
        if (!dir_q) begin
          stage_d[wa[2:0]] = wd;
          mask_d[wa[2:0]]  = 1'b1;
        end
      end else begin
        case (wa)
          touch_ctrl_pkg::ADDR_COMP_MODE: begin
            if (wd[touch_ctrl_pkg::MODE_COMP_BIT]) begin
              comp_d = 1'b1;
              ctmr_d = 16'(COMP_CYCLES - 1);
            end
            if (wd[1:0] != touch_ctrl_pkg::MODE_RESERVED) mode_d = wd[1:0];
          end
          touch_ctrl_pkg::ADDR_GPO_CTRL: begin
            for (int i = 0; i < 8; i++) begin
              if (gpo_pin_mask_i[i]) begin
                gpo_d[i] = wd[i];
                if (!autolight_en_i) inten_d[i] = wd[i] ? on_level_i : off_level_i;
              end
            end
          end
          touch_ctrl_pkg::ADDR_PIN_SELECT: sel_d = wd[2:0];
          touch_ctrl_pkg::ADDR_INTENSITY:  inten_d[sel_q] = wd;
          touch_ctrl_pkg::ADDR_GW_CONFIG: begin
            gwen_d = wd[touch_ctrl_pkg::GW_EN_LSB +: 2];
            dir_d  = wd[touch_ctrl_pkg::GW_DIR_BIT];
          end
          touch_ctrl_pkg::ADDR_BURST_BASE: begin
            if (khi_q == touch_ctrl_pkg::KEY_UPPER_VAL && klo_q == touch_ctrl_pkg::KEY_LOWER_VAL &&
                wd == touch_ctrl_pkg::BURN_GO_1) begin
              seq_d = 2'h1;
            end else if (seq_q == 2'h1 && wd == touch_ctrl_pkg::BURN_GO_2) begin
              seq_d = 2'h2;
            end else begin
              seq_d  = 2'h0;
              base_d = {1'b0, wd[6:3], 3'h0};
            end
          end
          touch_ctrl_pkg::ADDR_KEY_UPPER: khi_d = wd;
          touch_ctrl_pkg::ADDR_KEY_LOWER: klo_d = wd;
          touch_ctrl_pkg::ADDR_SOFT_RESET: begin
            srp_d = arm_q && (wd == touch_ctrl_pkg::SOFT_RST_2);
            arm_d = (wd == touch_ctrl_pkg::SOFT_RST_1);
          end
          default: ;
        endcase
      end
    end
    // Only the STOP after the second go byte starts a burn; sleep refuses it, as it needs the sensing engine.
    if (stop && seq_q == 2'h2) begin
      if (!busy_q && mode_q != touch_ctrl_pkg::MODE_SLEEP) begin
        busy_d = 1'b1;
        btmr_d = 16'(BURN_CYCLES - 1);
        khi_d  = 8'h00;
        klo_d  = 8'h00;
      end
      seq_d = 2'h0;
    end
    // Soft reset returns the control state; burn history survives as it is non-volatile.
    if (srp_q) begin
      init_d = 1'b0; mode_d = touch_ctrl_pkg::MODE_ACTIVE; comp_d = 1'b0; sel_d = 3'h0;
      gwen_d = 2'h0; dir_d = 1'b0; base_d = 8'h00; khi_d = 8'h00; klo_d = 8'h00;
      seq_d = 2'h0; arm_d = 1'b0; mask_d = 8'h00;
    end
    acc_d  = (gwen_d == touch_ctrl_pkg::GW_EN_ON);
    irqn_d = ~flag_d;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gpo_q <= 8'h00; base_q <= 8'h00; khi_q <= 8'h00; klo_q <= 8'h00; mask_q <= 8'h00;
      inten_q <= '{default: 8'h00};
      stage_q <= '{default: 8'h00};
      mode_q <= touch_ctrl_pkg::MODE_ACTIVE; gwen_q <= 2'h0; seq_q <= 2'h0; sel_q <= 3'h0;
      cnt_q <= 3'h0; ctmr_q <= 16'h0000; btmr_q <= 16'h0000; init_q <= 1'b0; comp_q <= 1'b0;
      dir_q <= 1'b0; busy_q <= 1'b0; valid_q <= 1'b0; flag_q <= 1'b0; irqn_q <= 1'b1;
      arm_q <= 1'b0; srp_q <= 1'b0; acc_q <= 1'b0;
    end else begin
      gpo_q <= gpo_d; base_q <= base_d; khi_q <= khi_d; klo_q <= klo_d; mask_q <= mask_d;
      inten_q <= inten_d; stage_q <= stage_d; mode_q <= mode_d; gwen_q <= gwen_d;
      seq_q <= seq_d; sel_q <= sel_d; cnt_q <= cnt_d; ctmr_q <= ctmr_d; btmr_q <= btmr_d;
      init_q <= init_d; comp_q <= comp_d; dir_q <= dir_d; busy_q <= busy_d; valid_q <= valid_d;
      flag_q <= flag_d; irqn_q <= irqn_d; arm_q <= arm_d; srp_q <= srp_d; acc_q <= acc_d;
    end
  end

  // The parameter memory has no reset; its content is owned by the burst traffic.
  always_ff @(posedge clk_i) begin
    if (mask_q == touch_ctrl_pkg::BURST_FULL && gw_on) begin
      for (int i = 0; i < touch_ctrl_pkg::BURST_LEN; i++) begin
        mem_q[{base_q[6:3], 3'(i)}] <= stage_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    if (in_window(ptr, gw_on)) begin
      if (dir_q) rd_data = mem_q[{base_q[6:3], ptr[2:0]}];
    end else begin
      case (ptr)
        touch_ctrl_pkg::ADDR_MEM_STATUS: rd_data = {4'h0, valid_q, cnt_q};
        touch_ctrl_pkg::ADDR_COMP_MODE:  rd_data = {5'h00, comp_q, mode_q};
        touch_ctrl_pkg::ADDR_GPO_CTRL:   rd_data = gpo_q;
        touch_ctrl_pkg::ADDR_PIN_SELECT: rd_data = {5'h00, sel_q};
        touch_ctrl_pkg::ADDR_INTENSITY:  rd_data = inten_q[sel_q];
        touch_ctrl_pkg::ADDR_GW_CONFIG:  rd_data = {2'h0, gwen_q, dir_q, 3'h0};
        touch_ctrl_pkg::ADDR_BURST_BASE: rd_data = base_q;
        touch_ctrl_pkg::ADDR_KEY_UPPER:  rd_data = khi_q;
        touch_ctrl_pkg::ADDR_KEY_LOWER:  rd_data = klo_q;
        default:                         rd_data = 8'h00;
      endcase
    end
  end

  assign op_mode_o            = mode_q;
  assign comp_running_o       = comp_q;
  assign general_output_pin_o = gpo_q;
  for (genvar g = 0; g < 8; g++) begin : g_pwm
    assign pwm_intensity_o[g*8 +: 8] = inten_q[g];
  end
  assign param_access_on_o    = acc_q;
  assign burn_busy_o          = busy_q;
  assign burn_flag_o          = flag_q;
  assign interrupt_line_n_o   = irqn_q;
  assign soft_reset_o         = srp_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire logic mode_wr = wr && wa == touch_ctrl_pkg::ADDR_COMP_MODE && !srp_q;

  property p_mode_keep;
    @(posedge clk_i) disable iff (!rst_n) mode_wr && wd[1:0] == 2'h3 |=> $stable(op_mode_o);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("reserved mode changed mode");
  property p_mode_set;
    @(posedge clk_i) disable iff (!rst_n) mode_wr && wd[1:0] != 2'h3 |=> op_mode_o == $past(wd[1:0]);
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode write not applied");
  property p_comp_start;
    @(posedge clk_i) disable iff (!rst_n) mode_wr && wd[2] |=> comp_running_o [*2];
  endproperty
  a_comp_start: assert property (p_comp_start) else $error("compensation not started");
  property p_comp_end;
    @(posedge clk_i) disable iff (!rst_n) comp_q && ctmr_q == 16'h0000 && !mode_wr |=> !comp_running_o;
  endproperty
  a_comp_end: assert property (p_comp_end) else $error("compensation did not finish");
  property p_valid_count;
    @(posedge clk_i) disable iff (!rst_n) valid_q |-> cnt_q inside {3'h1, 3'h2, 3'h3};
  endproperty
  a_valid_count: assert property (p_valid_count) else $error("valid with bad burn count");
  property p_count_max;
    @(posedge clk_i) disable iff (!rst_n) cnt_q <= 3'h4;
  endproperty
  a_count_max: assert property (p_count_max) else $error("burn count above four");
  property p_burn_done;
    @(posedge clk_i) disable iff (!rst_n) busy_q && btmr_q == 16'h0000 |=> burn_flag_o && !interrupt_line_n_o && !burn_busy_o;
  endproperty
  a_burn_done: assert property (p_burn_done) else $error("burn end not flagged");
  property p_burn_start;
    @(posedge clk_i) disable iff (!rst_n) $rose(burn_busy_o) |-> $past(stop) && $past(seq_q) == 2'h2;
  endproperty
  a_burn_start: assert property (p_burn_start) else $error("burn started without sequence");
  property p_soft_reset;
    @(posedge clk_i) disable iff (!rst_n) soft_reset_o |-> $past(wr) && $past(wd) == 8'h00 && $past(arm_q);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset without sequence");
  property p_rearm;
    @(posedge clk_i) disable iff (!rst_n)
      wr && wa == touch_ctrl_pkg::ADDR_SOFT_RESET && wd != 8'hde |=> !arm_q ##1 !soft_reset_o;
  endproperty
  a_rearm: assert property (p_rearm) else $error("soft reset detector not re-armed");
  property p_gpo_mask;
    @(posedge clk_i) disable iff (!rst_n)
      init_q && !srp_q && $stable(gpo_pin_mask_i) |=> (gpo_q & ~gpo_pin_mask_i) == $past(gpo_q & ~gpo_pin_mask_i);
  endproperty
  a_gpo_mask: assert property (p_gpo_mask) else $error("unconfigured output bit changed");
  property p_sel_read;
    @(posedge clk_i) disable iff (!rst_n)
      rd && ra == touch_ctrl_pkg::ADDR_INTENSITY && !gw_on |-> $past(rd_data) == $past(inten_q[sel_q]);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("intensity read wrong pin");
  property p_commit;
    @(posedge clk_i) disable iff (!rst_n) mask_q == 8'hff |=> mask_q == 8'h00;
  endproperty
  a_commit: assert property (p_commit) else $error("full burst not committed");
  c_burn:  cover property (@(posedge clk_i) disable iff (!rst_n) $rose(burn_flag_o));
  c_reset: cover property (@(posedge clk_i) disable iff (!rst_n) soft_reset_o);
  c_burst: cover property (@(posedge clk_i) disable iff (!rst_n) mask_q == 8'hff);
  c_comp:  cover property (@(posedge clk_i) disable iff (!rst_n) $fell(comp_running_o));
endmodule : touch_ctrl_host_register_bank
`default_nettype wire

/* File: tb/i2c_host_model.sv */
// I2C host model that runs single-byte register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter logic [7:0] DEV_W = 8'h56
) (
  input  wire logic dev_oe_i,
  input  wire logic clk_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic drv_q = 1'b1;
  // SDA has a pull-up, so a line that nobody pulls low reads high.
  assign sda_o = drv_q & ~dev_oe_i;
  initial scl_o = 1'b1;
  // Four cycles a phase keeps both SCL phases above the three-cycle floor.
  task automatic hp();
    repeat (4) @(negedge clk_i);
  endtask : hp
  task automatic bit_io(input logic b, output logic r);
    drv_q = b;
    hp();
    scl_o = 1'b1;
    hp();
    r = sda_o;
    scl_o = 1'b0;
    hp();
  endtask : bit_io
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
  endtask : xfer
  task automatic edge_seq(input logic stop);
    drv_q = ~stop;
    hp();
    scl_o = 1'b1;
    hp();
    drv_q = stop;
    hp();
    scl_o = stop;
    hp();
  endtask : edge_seq
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [8:0] r;
    edge_seq(1'b0);
    xfer({DEV_W, 1'b1}, r);
    xfer({a, 1'b1}, r);
    xfer({v, 1'b1}, r);
    edge_seq(1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [8:0] r;
    edge_seq(1'b0);
    xfer({DEV_W, 1'b1}, r);
    xfer({a, 1'b1}, r);
    edge_seq(1'b0);
    xfer({DEV_W | 8'h01, 1'b1}, r);
    // A high ninth bit is the NACK that ends the read after one byte.
    xfer(9'h1ff, r);
    v = r[8:1];
    edge_seq(1'b1);
  endtask : rd
endmodule : i2c_host_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the host register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s %h %h", n, e, g); end end
module testbench;
  localparam logic [7:0] PWR = 8'h35;
  localparam logic [7:0] MSK = 8'h0f;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clr = 1'b0;
  logic        scl, sda, oe, sr, comp, acc, flag, irq_n, busy;
  logic [1:0]  mode;
  logic [7:0]  general_output_pin, v;
  logic [63:0] pwm;
  int          num_errors = 0, n_checks = 0, n_sr = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (sr === 1'b1) n_sr++;
  i2c_host_model host (.dev_oe_i(oe), .clk_i(clk), .scl_o(scl), .sda_o(sda));
  touch_ctrl_host_register_bank #(.BURN_CYCLES(64)) dut (.clk_i(clk), .arst_n_i(rst_n), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(oe), .output_powerup_state_i(PWR), .gpo_pin_mask_i(MSK),
    .on_level_i(8'hc8), .off_level_i(8'h11), .autolight_en_i(1'b0), .burn_flag_clear_i(clr),
    .op_mode_o(mode), .comp_running_o(comp), .general_output_pin_o(general_output_pin), .pwm_intensity_o(pwm),
    .param_access_on_o(acc), .burn_busy_o(busy), .burn_flag_o(flag), .interrupt_line_n_o(irq_n), .soft_reset_o(sr));
  task automatic t_reset();
    host.rd(touch_ctrl_pkg::ADDR_MEM_STATUS, v);
    `CHK("status", 8'h00, v)
    `CHK("gpo", PWR, general_output_pin)
    host.rd(8'h0c, v);
    `CHK("int0", 8'hc8, v)
  endtask : t_reset
  task automatic t_mode();
    for (int m = 1; m <= 3; m++) begin
      host.wr(8'h09, 8'(m % 3));
      repeat (4) @(negedge clk);
      host.rd(8'h09, v);
      `CHK("mode", 2'(m % 3), v[1:0])
    end
    host.wr(8'h09, 8'h03);
    `CHK("rsv", 2'h0, mode)
    host.wr(8'h09, 8'h04);
    `CHK("comp", 1'b1, comp)
    repeat (100) @(negedge clk);
    host.rd(8'h09, v);
    `CHK("done", 3'h0, v[2:0])
  endtask : t_mode
  task automatic t_pins();
    host.wr(8'h0a, 8'ha2);
    `CHK("gpo", 8'h32, general_output_pin)
    `CHK("pin1", 8'hc8, pwm[15:8])
    `CHK("pin0", 8'h11, pwm[7:0])
    host.wr(8'h0b, 8'h07);
    host.wr(8'h0c, 8'hff);
    host.rd(8'h0c, v);
    `CHK("int7", 8'hff, v)
    `CHK("pin7", 8'hff, pwm[63:56])
  endtask : t_pins
  task automatic t_burn();
    host.wr(8'hac, 8'h62);
    host.wr(8'had, 8'h9d);
    host.wr(8'h0e, 8'ha5);
    host.wr(8'h0e, 8'h5a);
    `CHK("busy", 1'b1, busy)
    for (int i = 0; i < 200 && flag !== 1'b1; i++) @(negedge clk);
    `CHK("flag", 1'b1, flag)
    `CHK("idle", 1'b0, busy)
    `CHK("irq", 1'b0, irq_n)
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    `CHK("irq_clr", 1'b1, irq_n)
    host.rd(touch_ctrl_pkg::ADDR_MEM_STATUS, v);
    `CHK("status", 8'h09, v)
  endtask : t_burn
  task automatic t_gate();
    host.wr(8'h0d, 8'h10);
    `CHK("acc", 1'b1, acc)
    host.wr(8'h0e, 8'h78);
    for (int i = 0; i < 8; i++) host.wr(8'(i), 8'h40 + 8'(i));
    host.wr(8'h0d, 8'h18);
    for (int i = 0; i < 8; i++) begin
      host.rd(8'(i), v);
      `CHK("mem", 8'h40 + 8'(i), v)
    end
    host.wr(8'h0d, 8'h00);
    `CHK("acc", 1'b0, acc)
  endtask : t_gate
  task automatic t_soft();
    n_sr = 0;
    host.wr(8'hb1, 8'hde);
    host.wr(8'hb1, 8'h12);
    host.wr(8'hb1, 8'h00);
    `CHK("no_rst", 0, n_sr)
    host.wr(8'h09, 8'h02);
    host.wr(8'hb1, 8'hde);
    host.wr(8'hb1, 8'h00);
    `CHK("rst", 1, n_sr)
    `CHK("mode", 2'h0, mode)
    `CHK("pin7", 8'h11, pwm[63:56])
  endtask : t_soft
  task automatic final_report();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    #250us;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_reset();
    t_mode();
    t_pins();
    t_burn();
    t_gate();
    t_soft();
    final_report();
  end
endmodule : testbench
`default_nettype wire
